// file: src/ksw_params.svh
`ifndef KSW_PARAMS_SVH
`define KSW_PARAMS_SVH
// ****************************************
// Register map
// ****************************************
`define KSW_OFS_SERVICE  8'ha6
`define KSW_OFS_CTRL     8'ha7
`define KSW_OFS_IRQ_STAT 8'ha8
`define KSW_OFS_IRQ_MASK 8'ha9
// ****************************************
// Control register fields
// ****************************************
`define KSW_CTRL_PS_HI   7
`define KSW_CTRL_PS_LO   5
`define KSW_CTRL_IDLE    4
`define KSW_CTRL_FLAG    1
`define KSW_CTRL_RUN     0
`define KSW_CTRL_RESET   8'h00
// ****************************************
// Key bytes and interrupt events
// ****************************************
`define KSW_KEY_FIRST    8'h1e
`define KSW_KEY_SECOND   8'he1
`define KSW_EV_TIMEOUT   0
`define KSW_EV_BADKEY    1
`define KSW_EV_FED       2
`define KSW_EV_RESET     3'h0
// ****************************************
// Counter geometry
// ****************************************
`define KSW_PRE_WIDTH    7
`define KSW_TMR_WIDTH    14
`endif

// file: src/ksw_pkg.sv
package ksw_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ksw_bus_req_type;

   typedef enum logic [0:0] {
      KSW_KEY_WAIT   = 1'b0,
      KSW_KEY_HALF   = 1'b1
   } ksw_key_state_type;

   typedef struct packed {
      logic [2:0] period_sel;
      logic       idle_freeze;
      logic       timeout_flag;
      logic       running_status;
   } ksw_ctrl_type;
endpackage

// file: src/ksw_watchdog.sv
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ksw_params.svh"

// Operation
// - Count advances every clock while enabled
// - Three-bit select doubles period, 16K..2048K
// - Any reset disables; power-down stops count
// - Expiry without service pulses system reset
// - Fourteen-bit timer behind seven-bit prescaler
// - Key 0x1E then 0xE1 starts timer
// - Running bit set once timer enabled
// - Correct key before expiry prevents reset
// - Other write between key bytes breaks sequence
// - Wrong key sequence resets immediately
// - Idle freeze bit stops count in idle
// - Overflow flag set on reset, software clears
// - Running bit read-only, writes ignored
module ksw_watchdog
   import ksw_pkg::*;
#(
   parameter int PRE_W = `KSW_PRE_WIDTH,
   parameter int TMR_W = `KSW_TMR_WIDTH
)
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire ksw_bus_req_type bus_req,
   output logic [7:0]           rdata,
   input  wire logic            idle,
   input  wire logic            power_down,
   output logic                 sys_reset_pulse,
   output logic                 irq
);

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic hit(input ksw_bus_req_type r, input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   // Prescaler tap: low ps bits all ones gives a divide by 2**ps
   function automatic logic pre_tick(input logic [PRE_W-1:0] pre,
                                     input logic [2:0]       ps);
      logic [PRE_W-1:0] m;
      m = {PRE_W{1'b1}} >> (3'(PRE_W) - ps);
      pre_tick = &(pre | ~m);
   endfunction

   // ****************************************
   // State
   // ****************************************
   ksw_ctrl_type      ctrl_q;
   ksw_key_state_type key_q;
   logic [PRE_W-1:0]  pre_q;
   logic [TMR_W-1:0]  tmr_q;
   logic [2:0]        irq_stat_q;
   logic [2:0]        irq_mask_q;
   logic [7:0]        rdata_q;
   logic              pulse_q;

   logic wr_service;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic wr_other;
   logic key_good;
   logic key_bad;
   logic cnt_en;
   logic tick;
   logic expire;
   logic wd_reset;
   logic [2:0] events;

   assign wr_service = bus_req.wr && hit(bus_req, `KSW_OFS_SERVICE);
   assign wr_ctrl    = bus_req.wr && hit(bus_req, `KSW_OFS_CTRL);
   assign wr_stat    = bus_req.wr && hit(bus_req, `KSW_OFS_IRQ_STAT);
   assign wr_mask    = bus_req.wr && hit(bus_req, `KSW_OFS_IRQ_MASK);
   assign wr_other   = bus_req.wr && !wr_service;

   // ****************************************
   // Key sequence
   // ****************************************
   // Second byte completes the key only if nothing else was written between
   assign key_good = wr_service && (key_q == KSW_KEY_HALF)
                     && (bus_req.wdata == `KSW_KEY_SECOND);
   // Reads between the two bytes are harmless; any other write is not
   assign key_bad  = (wr_service && (key_q == KSW_KEY_WAIT)
                      && (bus_req.wdata != `KSW_KEY_FIRST))
                   || (wr_service && (key_q == KSW_KEY_HALF)
                      && (bus_req.wdata != `KSW_KEY_SECOND))
                   || (wr_other && (key_q == KSW_KEY_HALF));

   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         key_q <= KSW_KEY_WAIT;
      else
      begin
         case (key_q)
            KSW_KEY_WAIT:
               if (wr_service && (bus_req.wdata == `KSW_KEY_FIRST))
                  key_q <= KSW_KEY_HALF;
            KSW_KEY_HALF:
               if (bus_req.wr)
                  key_q <= KSW_KEY_WAIT;
            default:
               key_q <= KSW_KEY_WAIT;
         endcase
      end
   end

   // ****************************************
   // Counter
   // ****************************************
   assign cnt_en = ctrl_q.running_status && !power_down
                   && !(idle && ctrl_q.idle_freeze);
   assign tick   = cnt_en && pre_tick(pre_q, ctrl_q.period_sel);
   assign expire = tick && (&tmr_q);
   // A good key in the expiry cycle still rescues the system
   assign wd_reset = key_bad || (expire && !key_good);

   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         pre_q <= '0;
         tmr_q <= '0;
      end
      else if (key_good || wd_reset)
      begin
         pre_q <= '0;
         tmr_q <= '0;
      end
      else if (cnt_en)
      begin
         pre_q <= pre_q + 1'b1;
         if (tick)
            tmr_q <= tmr_q + 1'b1;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         ctrl_q <= ksw_ctrl_type'(6'(`KSW_CTRL_RESET));
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_q.period_sel  <= bus_req.wdata[`KSW_CTRL_PS_HI:`KSW_CTRL_PS_LO];
            ctrl_q.idle_freeze <= bus_req.wdata[`KSW_CTRL_IDLE];
            if (!bus_req.wdata[`KSW_CTRL_FLAG])
               ctrl_q.timeout_flag <= 1'b0;
         end
         // Set wins over a clearing write in the same cycle
         if (wd_reset)
            ctrl_q.timeout_flag <= 1'b1;
         // Watchdog reset disables the timer like any other reset
         if (wd_reset)
            ctrl_q.running_status <= 1'b0;
         else if (key_good)
            ctrl_q.running_status <= 1'b1;
      end
   end

   // ****************************************
   // Reset pulse and interrupts
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         pulse_q <= 1'b0;
      else
         pulse_q <= wd_reset;
   end

   // Feeds are reported too, so software can see that its key landed
   assign events = {key_good, key_bad, expire && !key_good};

   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         irq_stat_q <= `KSW_EV_RESET;
         irq_mask_q <= `KSW_EV_RESET;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~(wr_stat ? bus_req.wdata[2:0] : 3'h0)) | events;
         if (wr_mask)
            irq_mask_q <= bus_req.wdata[2:0];
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   // Unmapped and write-only addresses read as zero
   always_ff @(posedge clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         rdata_q <= 8'h00;
      else if (!bus_req.rd)
         rdata_q <= 8'h00;
      else if (hit(bus_req, `KSW_OFS_CTRL))
         rdata_q <= {ctrl_q.period_sel, ctrl_q.idle_freeze, 2'b00,
                     ctrl_q.timeout_flag, ctrl_q.running_status};
      else if (hit(bus_req, `KSW_OFS_IRQ_STAT))
         rdata_q <= {5'h00, irq_stat_q};
      else if (hit(bus_req, `KSW_OFS_IRQ_MASK))
         rdata_q <= {5'h00, irq_mask_q};
      else
         rdata_q <= 8'h00;
   end

   assign rdata           = rdata_q;
   assign sys_reset_pulse = pulse_q;
   assign irq             = |(irq_stat_q & irq_mask_q);

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_q);

   a_bad_first_byte: assert property (
      (bus_req.wr && hit(bus_req, `KSW_OFS_SERVICE) && key_q == KSW_KEY_WAIT
       && bus_req.wdata != `KSW_KEY_FIRST) |=> sys_reset_pulse && ctrl_q.timeout_flag)
      else $error("wrong first key byte gave no reset");

   a_write_between_bytes: assert property (
      (key_q == KSW_KEY_HALF && bus_req.wr && !hit(bus_req, `KSW_OFS_SERVICE))
      |=> sys_reset_pulse && !ctrl_q.running_status)
      else $error("write between key bytes not treated as broken");

   a_key_starts_timer: assert property (
      (key_q == KSW_KEY_WAIT && bus_req.wr && hit(bus_req, `KSW_OFS_SERVICE)
       && bus_req.wdata == `KSW_KEY_FIRST)
      ##1 (bus_req.wr && hit(bus_req, `KSW_OFS_SERVICE)
           && bus_req.wdata == `KSW_KEY_SECOND)
      |=> ctrl_q.running_status && !sys_reset_pulse)
      else $error("good key did not start timer");

   a_feed_restarts: assert property (
      key_good |=> tmr_q == '0 && pre_q == '0 ##1 tmr_q <= TMR_W'(1))
      else $error("feed did not restart count");

   a_expiry_resets: assert property (
      (ctrl_q.running_status && cnt_en && (&tmr_q) && tick && !bus_req.wr)
      |=> sys_reset_pulse ##1 !sys_reset_pulse)
      else $error("expiry gave no single reset pulse");

   a_power_down_hold: assert property (
      (power_down && !bus_req.wr) |=> $stable(pre_q) && $stable(tmr_q))
      else $error("count moved in power-down");

   a_idle_freeze_hold: assert property (
      (idle && ctrl_q.idle_freeze && !bus_req.wr) |=> $stable(pre_q))
      else $error("count moved in frozen idle");

   a_idle_counts_on: assert property (
      (idle && !ctrl_q.idle_freeze && ctrl_q.running_status && !power_down
       && !bus_req.wr) |=> pre_q == $past(pre_q) + 1'b1)
      else $error("count stopped in idle without freeze");

   a_running_readonly: assert property (
      (bus_req.wr && hit(bus_req, `KSW_OFS_CTRL) && key_q == KSW_KEY_WAIT)
      |=> ctrl_q.running_status == $past(ctrl_q.running_status))
      else $error("control write changed running bit");

   a_flag_sticky: assert property (
      (ctrl_q.timeout_flag && !(bus_req.wr && hit(bus_req, `KSW_OFS_CTRL)))
      |=> ctrl_q.timeout_flag)
      else $error("overflow flag dropped without clear");

   a_period_step: assert property (
      (cnt_en && !bus_req.wr && pre_q == '1) |=> tmr_q == $past(tmr_q) + 1'b1)
      else $error("timer missed prescaler wrap");

   a_count_runs: assert property (
      (cnt_en && !bus_req.wr && !expire) |=> pre_q == $past(pre_q) + 1'b1)
      else $error("enabled count did not advance");

   a_stopped_no_count: assert property (
      (!ctrl_q.running_status && !bus_req.wr) |=> $stable(pre_q) && $stable(tmr_q))
      else $error("stopped timer moved");

   a_timeout_sets_flag: assert property (
      (expire && !key_good)
      |=> ctrl_q.timeout_flag && !ctrl_q.running_status && tmr_q == '0)
      else $error("expiry did not set flag and stop timer");

   a_good_key_clean: assert property (
      key_good |=> ctrl_q.running_status && !sys_reset_pulse)
      else $error("good key gave reset or no running bit");

   a_read_keeps_half: assert property (
      (key_q == KSW_KEY_HALF && !bus_req.wr) |=> key_q == KSW_KEY_HALF)
      else $error("read broke a half key");

   a_read_running_bit: assert property (
      (bus_req.rd && hit(bus_req, `KSW_OFS_CTRL))
      |=> rdata[`KSW_CTRL_RUN] == $past(ctrl_q.running_status))
      else $error("running bit read back wrong");

   a_service_write_only: assert property (
      (bus_req.rd && hit(bus_req, `KSW_OFS_SERVICE)) |=> rdata == 8'h00)
      else $error("service register read not zero");

   a_read_zero_idle: assert property (
      !bus_req.rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");

   a_mask_write: assert property (
      (bus_req.wr && hit(bus_req, `KSW_OFS_IRQ_MASK)) |=> irq_mask_q == $past(bus_req.wdata[2:0]))
      else $error("mask write did not land");

   a_status_w1c: assert property (
      (bus_req.wr && hit(bus_req, `KSW_OFS_IRQ_STAT) && events == 3'h0)
      |=> (irq_stat_q & $past(bus_req.wdata[2:0])) == 3'h0)
      else $error("status write one did not clear");

   c_enable_seen: cover property (key_good && !ctrl_q.running_status);
   c_feed_seen: cover property (key_good && ctrl_q.running_status);
   c_timeout_seen: cover property (expire && !key_good);
   c_broken_key_seen: cover property (key_bad && key_q == KSW_KEY_HALF);
   c_power_down_seen: cover property (power_down && ctrl_q.running_status);
endmodule

// file: tb/test_keyed_sequence_watchdog.sv
`timescale 1ns/1ps
`include "ksw_params.svh"
module test_keyed_sequence_watchdog
   import ksw_pkg::*;
();
   localparam logic [7:0] A_SVC = `KSW_OFS_SERVICE;
   localparam logic [7:0] A_CTL = `KSW_OFS_CTRL;
   localparam logic [7:0] A_STA = `KSW_OFS_IRQ_STAT;
   localparam logic [7:0] A_MSK = `KSW_OFS_IRQ_MASK;

   logic            clk;
   logic            rst_n;
   ksw_bus_req_type bus_req;
   logic [7:0]      rdata;
   logic            idle;
   logic            power_down;
   logic            sys_reset_pulse;
   logic            irq;
   int              n_errors;
   int              checks;

   ksw_watchdog dut_u
   (
      .clk             (clk),
      .rst_n           (rst_n),
      .bus_req         (bus_req),
      .rdata           (rdata),
      .idle            (idle),
      .power_down      (power_down),
      .sys_reset_pulse (sys_reset_pulse),
      .irq             (irq)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************
   // Bus tasks and checks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Two back-to-back service writes, strobe held across both
   task automatic key(input logic [7:0] second);
      @(posedge clk);
      bus_req <= '{addr: A_SVC, wdata: `KSW_KEY_FIRST, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus_req.wdata <= second;
      @(posedge clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   // Counts cycles until the reset pulse shows, up to max
   task automatic pulse(input int lo, input int hi, input int max);
      int n;
      n = 0;
      #1;
      while (sys_reset_pulse !== 1'b1 && n < max)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({7'h00, (n >= lo && n <= hi)}, 8'h01);
      if (n < max)
      begin
         @(posedge clk);
         #1;
         chk({7'h00, sys_reset_pulse}, 8'h00);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      n_errors = 0;
      checks = 0;
      rst_n = 1'b0;
      idle = 1'b0;
      power_down = 1'b0;
      bus_req = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rchk(A_CTL, 8'h00);
      rchk(A_SVC, 8'h00);
      rchk(8'h00, 8'h00);
      wr(A_CTL, 8'hff);
      rchk(A_CTL, 8'hf0);
      wr(A_MSK, 8'h07);
      $display("test access done");
      wr(A_CTL, 8'h00);
      wr(A_SVC, `KSW_KEY_FIRST);
      rchk(A_CTL, 8'h00);
      wr(A_MSK, 8'h07);
      pulse(0, 1, 4);
      rchk(A_CTL, 8'h02);
      rchk(A_STA, 8'h02);
      chk({7'h00, irq}, 8'h01);
      wr(A_STA, 8'h07);
      chk({7'h00, irq}, 8'h00);
      key(8'h55);
      pulse(0, 1, 4);
      wr(A_SVC, 8'h55);
      pulse(0, 1, 4);
      wr(A_CTL, 8'h00);
      rchk(A_CTL, 8'h00);
      wr(A_STA, 8'h07);
      $display("test bad key done");
      wr(A_SVC, `KSW_KEY_FIRST);
      rchk(A_CTL, 8'h00);
      wr(A_SVC, `KSW_KEY_SECOND);
      rchk(A_CTL, 8'h01);
      rchk(A_STA, 8'h04);
      chk({7'h00, irq}, 8'h01);
      wr(A_MSK, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wr(A_MSK, 8'h07);
      wr(A_STA, 8'h07);
      chk({7'h00, irq}, 8'h00);
      // Feed near mid-period, then let it expire
      pulse(10000, 10000, 10000);
      key(`KSW_KEY_SECOND);
      pulse(16383, 16387, 17000);
      rchk(A_CTL, 8'h02);
      rchk(A_STA, 8'h05);
      $display("test feed and timeout done");
      wr(A_CTL, 8'h20);
      wr(A_STA, 8'h07);
      key(`KSW_KEY_SECOND);
      @(posedge clk);
      power_down <= 1'b1;
      pulse(2000, 2000, 2000);
      @(posedge clk);
      power_down <= 1'b0;
      pulse(32760, 32770, 34000);
      $display("test power down done");
      wr(A_CTL, 8'h10);
      key(`KSW_KEY_SECOND);
      @(posedge clk);
      idle <= 1'b1;
      pulse(2000, 2000, 2000);
      wr(A_CTL, 8'h00);
      pulse(16370, 16390, 17000);
      @(posedge clk);
      idle <= 1'b0;
      $display("test idle done");
      stop_test();
   end

   // Tests need about 80000 cycles
   initial
   begin
      #(95000 * 5);
      n_errors++;
      stop_test();
   end
endmodule
